/* File: common/cpuamg_pkg.sv */
// package of constants and types for the cpu address mode generator
package cpuamg_pkg;
    // =========================================================
    // widths
    localparam int unsigned CPUAMG_AW = 24;
    // =========================================================
    // fixed addresses
    localparam logic [23:0] CPUAMG_VEC_LO = 24'h00FFE0;
    localparam logic [23:0] CPUAMG_VEC_HI = 24'h00FFFF;
    localparam logic [7:0] CPUAMG_BANK0 = 8'h00;
    // =========================================================
    // reset values
    localparam logic [7:0] CPUAMG_RST_PBR = 8'h00;
    localparam logic [15:0] CPUAMG_RST_PC = 16'h0000;
    // =========================================================
    // cycle counts
    localparam logic [3:0] CPUAMG_CYC_IMM = 4'h2;
    localparam logic [3:0] CPUAMG_CYC_ABS = 4'h4;
    localparam logic [3:0] CPUAMG_CYC_ABSL = 4'h5;
    localparam logic [3:0] CPUAMG_CYC_DIR = 4'h3;
    localparam logic [3:0] CPUAMG_CYC_ACC = 4'h2;
    localparam logic [3:0] CPUAMG_CYC_DIIY = 4'h5;
    localparam logic [3:0] CPUAMG_CYC_DILY = 4'h6;
    localparam logic [3:0] CPUAMG_CYC_DXI = 4'h6;
    localparam logic [3:0] CPUAMG_CYC_DX = 4'h4;
    localparam logic [3:0] CPUAMG_CYC_REL = 4'h2;
    localparam logic [3:0] CPUAMG_CYC_RELL = 4'h3;
    localparam logic [3:0] CPUAMG_CYC_AIND = 4'h5;
    localparam logic [3:0] CPUAMG_CYC_DI = 4'h5;
    localparam logic [3:0] CPUAMG_CYC_AXI = 4'h6;
    localparam logic [3:0] CPUAMG_CYC_STK = 4'h3;
    localparam logic [3:0] CPUAMG_CYC_SR = 4'h4;
    localparam logic [3:0] CPUAMG_CYC_SRIY = 4'h7;
    localparam logic [3:0] CPUAMG_CYC_BLK = 4'h7;
    localparam logic [3:0] CPUAMG_CYC_RMW8 = 4'h2;
    localparam logic [3:0] CPUAMG_CYC_RMW16 = 4'h3;
    localparam logic [3:0] CPUAMG_CYC_ONE = 4'h1;
    // =========================================================
    // program byte counts
    localparam logic [2:0] CPUAMG_LEN_1 = 3'h1;
    localparam logic [2:0] CPUAMG_LEN_2 = 3'h2;
    localparam logic [2:0] CPUAMG_LEN_3 = 3'h3;
    localparam logic [2:0] CPUAMG_LEN_4 = 3'h4;
    // =========================================================
    // addressing modes
    typedef enum logic [4:0] {
        CPUAMG_M_IMM = 5'h00,
        CPUAMG_M_ABS = 5'h01,
        CPUAMG_M_ABSL = 5'h02,
        CPUAMG_M_DIR = 5'h03,
        CPUAMG_M_ACC = 5'h04,
        CPUAMG_M_IMPL = 5'h05,
        CPUAMG_M_DIIY = 5'h06,
        CPUAMG_M_DILY = 5'h07,
        CPUAMG_M_DXI = 5'h08,
        CPUAMG_M_DX = 5'h09,
        CPUAMG_M_DY = 5'h0A,
        CPUAMG_M_AX = 5'h0B,
        CPUAMG_M_ALX = 5'h0C,
        CPUAMG_M_AY = 5'h0D,
        CPUAMG_M_REL = 5'h0E,
        CPUAMG_M_RELL = 5'h0F,
        CPUAMG_M_AIND = 5'h10,
        CPUAMG_M_DI = 5'h11,
        CPUAMG_M_DIL = 5'h12,
        CPUAMG_M_AXI = 5'h13,
        CPUAMG_M_STK = 5'h14,
        CPUAMG_M_SR = 5'h15,
        CPUAMG_M_SRIY = 5'h16,
        CPUAMG_M_BLK = 5'h17,
        CPUAMG_M_VEC = 5'h18
    } cpuamg_mode_t;
    // =========================================================
    // program bank load sources
    typedef enum logic [2:0] {
        CPUAMG_PB_NONE = 3'h0,
        CPUAMG_PB_RTI = 3'h1,
        CPUAMG_PB_RTL = 3'h2,
        CPUAMG_PB_JML = 3'h3,
        CPUAMG_PB_JSL = 3'h4,
        CPUAMG_PB_JMPL = 3'h5
    } cpuamg_pbop_t;
endpackage

/* File: src/cpuamg_cycles.sv */
// cycle and program byte count for one addressing mode
`timescale 1ns/1ns
module cpuamg_cycles
    import cpuamg_pkg::*;
(
    input wire cpuamg_mode_t mode,
    input wire logic m_flag,
    input wire logic x_flag,
    input wire logic idx_op,
    input wire logic dl_nz,
    input wire logic page_cross,
    input wire logic branch_taken,
    input wire logic rmw,
    input wire logic [7:0] stack_cycles,
    output logic [3:0] cycles,
    output logic [2:0] bytes_len
);
    logic wide;
    logic [3:0] base;
    logic use_w;
    logic use_dl;
    logic use_pg;
    always_comb begin
        wide = idx_op ? ~x_flag : ~m_flag;
        base = CPUAMG_CYC_IMM;
        bytes_len = CPUAMG_LEN_2;
        use_w = 1'b1;
        use_dl = 1'b0;
        use_pg = 1'b0;
        case (mode)
            CPUAMG_M_IMM: begin
                base = CPUAMG_CYC_IMM;
                bytes_len = wide ? CPUAMG_LEN_3 : CPUAMG_LEN_2;
            end
            CPUAMG_M_ABS: begin
                base = CPUAMG_CYC_ABS;
                bytes_len = CPUAMG_LEN_3;
            end
            CPUAMG_M_ABSL, CPUAMG_M_ALX: begin
                base = CPUAMG_CYC_ABSL;
                bytes_len = CPUAMG_LEN_4;
            end
            CPUAMG_M_DIR: begin
                base = CPUAMG_CYC_DIR;
                use_dl = 1'b1;
            end
            CPUAMG_M_ACC, CPUAMG_M_IMPL: begin
                base = CPUAMG_CYC_ACC;
                bytes_len = CPUAMG_LEN_1;
                use_w = 1'b0;
            end
            CPUAMG_M_DIIY: begin
                base = CPUAMG_CYC_DIIY;
                use_dl = 1'b1;
                use_pg = 1'b1;
            end
            CPUAMG_M_DILY, CPUAMG_M_DIL: begin
                base = CPUAMG_CYC_DILY;
                use_dl = 1'b1;
            end
            CPUAMG_M_DXI: begin
                base = CPUAMG_CYC_DXI;
                use_dl = 1'b1;
            end
            CPUAMG_M_DX, CPUAMG_M_DY: begin
                base = CPUAMG_CYC_DX;
                use_dl = 1'b1;
            end
            CPUAMG_M_AX, CPUAMG_M_AY: begin
                base = CPUAMG_CYC_ABS;
                bytes_len = CPUAMG_LEN_3;
                use_pg = 1'b1;
            end
            CPUAMG_M_REL: begin
                base = CPUAMG_CYC_REL;
                use_w = 1'b0;
            end
            CPUAMG_M_RELL: begin
                base = CPUAMG_CYC_RELL;
                bytes_len = CPUAMG_LEN_3;
                use_w = 1'b0;
            end
            CPUAMG_M_AIND: begin
                base = CPUAMG_CYC_AIND;
                bytes_len = CPUAMG_LEN_3;
                use_w = 1'b0;
            end
            CPUAMG_M_DI: begin
                base = CPUAMG_CYC_DI;
                use_dl = 1'b1;
            end
            CPUAMG_M_AXI: begin
                base = CPUAMG_CYC_AXI;
                bytes_len = CPUAMG_LEN_3;
                use_w = 1'b0;
            end
            CPUAMG_M_STK, CPUAMG_M_VEC: begin
                base = stack_cycles[3:0];
                bytes_len = CPUAMG_LEN_1;
                use_w = 1'b0;
            end
            CPUAMG_M_SR: begin
                base = CPUAMG_CYC_SR;
            end
            CPUAMG_M_SRIY: begin
                base = CPUAMG_CYC_SRIY;
            end
            CPUAMG_M_BLK: begin
                base = CPUAMG_CYC_BLK;
                bytes_len = CPUAMG_LEN_3;
                use_w = 1'b0;
            end
            default: begin
                base = CPUAMG_CYC_IMM;
            end
        endcase
        cycles = base;
        if (use_w && wide) begin
            cycles = cycles + CPUAMG_CYC_ONE;
        end
        if (use_dl && dl_nz) begin
            cycles = cycles + CPUAMG_CYC_ONE;
        end
        if (use_pg && page_cross) begin
            cycles = cycles + CPUAMG_CYC_ONE;
        end
        if ((mode == CPUAMG_M_REL || mode == CPUAMG_M_RELL) && branch_taken) begin
            cycles = cycles + CPUAMG_CYC_ONE;
        end
        if (rmw) begin
            cycles = cycles + (m_flag ? CPUAMG_CYC_RMW8 : CPUAMG_CYC_RMW16);
        end
    end
endmodule // cpuamg_cycles

/* File: src/cpuamg_top.sv */
// effective address and cycle count generator
// =========================================================
`timescale 1ns/1ns
module cpuamg_top
    import cpuamg_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic START,
    input wire cpuamg_mode_t MODE,
    input wire logic [7:0] OP_B2,
    input wire logic [7:0] OP_B3,
    input wire logic [7:0] OP_B4,
    input wire logic [15:0] PTR_DATA,
    input wire logic [7:0] PTR_BANK,
    input wire logic [7:0] DATA_BANK_REG,
    input wire logic [15:0] DIRECT_PAGE,
    input wire logic [15:0] X_REG,
    input wire logic [15:0] Y_REG,
    input wire logic [15:0] S_REG,
    input wire logic [15:0] C_ACC,
    input wire logic [3:0] VEC_SEL,
    input wire logic M_FLAG,
    input wire logic X_FLAG,
    input wire logic IDX_OP,
    input wire logic RMW,
    input wire logic BRANCH_TAKEN,
    input wire logic [7:0] STACK_CYCLES,
    input wire logic PC_INC,
    input wire logic PC_LOAD,
    input wire logic [15:0] PC_NEW,
    input wire cpuamg_pbop_t PB_OP,
    input wire logic [7:0] PB_NEW,
    input wire logic BANK_OUT_EN,
    output logic [23:0] EFF_ADDR,
    output logic [7:0] BANK_PINS,
    output logic [15:0] IMM_OPERAND,
    output logic [15:0] PTR_ADDR,
    output logic [3:0] CYCLES,
    output logic [2:0] PROG_BYTES,
    output logic [15:0] BLK_COUNT,
    output logic [23:0] BLK_SRC,
    output logic [23:0] BLK_DST,
    output logic [15:0] PC_OUT,
    output logic [7:0] PBR_OUT,
    output logic VALID
);
    // =========================================================
    // helpers
    function automatic logic [23:0] add24(input logic [23:0] a, input logic [15:0] b);
        add24 = a + {8'h00, b};
    endfunction
    function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
        add16 = a + b;
    endfunction
    function automatic logic page_x(input logic [15:0] a, input logic [15:0] b);
        logic [15:0] s;
        s = a + b;
        page_x = (s[15:8] != a[15:8]);
    endfunction

    // =========================================================
    // address forming
    logic [23:0] ea;
    logic [15:0] ptr;
    logic [15:0] imm;
    logic pcross;
    logic [15:0] abs16;
    logic [15:0] dpo;
    logic [23:0] base24;
    always_comb begin
        abs16 = {OP_B3, OP_B2};
        dpo = add16(DIRECT_PAGE, {8'h00, OP_B2});
        ea = {CPUAMG_BANK0, dpo};
        ptr = dpo;
        pcross = 1'b0;
        base24 = {DATA_BANK_REG, PTR_DATA};
        imm = ((IDX_OP ? X_FLAG : M_FLAG) == 1'b0) ? {OP_B3, OP_B2} : {8'h00, OP_B2};
        case (MODE)
            CPUAMG_M_ABS: begin
                ea = {DATA_BANK_REG, abs16};
            end
            CPUAMG_M_ABSL: begin
                ea = {OP_B4, OP_B3, OP_B2};
            end
            CPUAMG_M_DIR: begin
                ea = {CPUAMG_BANK0, dpo};
            end
            CPUAMG_M_DX: begin
                ea = {CPUAMG_BANK0, add16(dpo, X_REG)};
            end
            CPUAMG_M_DY: begin
                ea = {CPUAMG_BANK0, add16(dpo, Y_REG)};
            end
            CPUAMG_M_DIIY: begin
                ea = add24(base24, Y_REG);
                pcross = page_x(PTR_DATA, Y_REG);
            end
            CPUAMG_M_DILY: begin
                ea = add24({PTR_BANK, PTR_DATA}, Y_REG);
            end
            CPUAMG_M_DXI: begin
                ptr = add16(dpo, X_REG);
                ea = base24;
            end
            CPUAMG_M_DI: begin
                ea = base24;
            end
            CPUAMG_M_DIL: begin
                ea = {PTR_BANK, PTR_DATA};
            end
            CPUAMG_M_AX: begin
                ea = add24({DATA_BANK_REG, abs16}, X_REG);
                pcross = page_x(abs16, X_REG);
            end
            CPUAMG_M_AY: begin
                ea = add24({DATA_BANK_REG, abs16}, Y_REG);
                pcross = page_x(abs16, Y_REG);
            end
            CPUAMG_M_ALX: begin
                ea = add24({OP_B4, OP_B3, OP_B2}, X_REG);
            end
            CPUAMG_M_AIND: begin
                ptr = abs16;
                ea = {CPUAMG_BANK0, abs16};
            end
            CPUAMG_M_AXI: begin
                ptr = add16(abs16, X_REG);
                ea = {CPUAMG_BANK0, ptr};
            end
            CPUAMG_M_STK: begin
                ea = {CPUAMG_BANK0, S_REG};
            end
            CPUAMG_M_SR: begin
                ea = {CPUAMG_BANK0, add16(S_REG, {8'h00, OP_B2})};
            end
            CPUAMG_M_SRIY: begin
                ptr = add16(S_REG, {8'h00, OP_B2});
                ea = add24(base24, Y_REG);
            end
            CPUAMG_M_BLK: begin
                ea = {OP_B3, X_REG};
            end
            CPUAMG_M_VEC: begin
                ea = {CPUAMG_VEC_LO[23:4], VEC_SEL} | CPUAMG_VEC_LO;
            end
            default: begin
                ea = {CPUAMG_BANK0, dpo};
            end
        endcase
    end

    // =========================================================
    // cycle counting
    logic [3:0] cyc;
    logic [2:0] blen;
    cpuamg_cycles u_cycles (
        .mode(MODE),
        .m_flag(M_FLAG),
        .x_flag(X_FLAG),
        .idx_op(IDX_OP),
        .dl_nz(DIRECT_PAGE[7:0] != 8'h00),
        .page_cross(pcross),
        .branch_taken(BRANCH_TAKEN),
        .rmw(RMW),
        .stack_cycles(STACK_CYCLES),
        .cycles(cyc),
        .bytes_len(blen)
    );

    // =========================================================
    // registered results
    logic [23:0] ea_ff;
    logic [23:0] nxt_ea;
    logic [15:0] imm_ff;
    logic [15:0] nxt_imm;
    logic [15:0] ptr_ff;
    logic [15:0] nxt_ptr;
    logic [3:0] cyc_ff;
    logic [3:0] nxt_cyc;
    logic [2:0] len_ff;
    logic [2:0] nxt_len;
    logic [15:0] blkc_ff;
    logic [15:0] nxt_blkc;
    logic [23:0] bsrc_ff;
    logic [23:0] nxt_bsrc;
    logic [23:0] bdst_ff;
    logic [23:0] nxt_bdst;
    logic val_ff;
    logic nxt_val;
    always_comb begin
        nxt_ea = ea_ff;
        nxt_imm = imm_ff;
        nxt_ptr = ptr_ff;
        nxt_cyc = cyc_ff;
        nxt_len = len_ff;
        nxt_blkc = blkc_ff;
        nxt_bsrc = bsrc_ff;
        nxt_bdst = bdst_ff;
        nxt_val = START;
        if (START) begin
            nxt_ea = ea;
            nxt_imm = imm;
            nxt_ptr = ptr;
            nxt_cyc = cyc;
            nxt_len = blen;
            if (MODE == CPUAMG_M_BLK) begin
                nxt_blkc = C_ACC;
                nxt_bsrc = {OP_B3, X_REG};
                nxt_bdst = {OP_B2, Y_REG};
            end
        end
    end
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ea_ff <= 24'h000000;
            imm_ff <= 16'h0000;
            ptr_ff <= 16'h0000;
            cyc_ff <= 4'h0;
            len_ff <= 3'h0;
            blkc_ff <= 16'h0000;
            bsrc_ff <= 24'h000000;
            bdst_ff <= 24'h000000;
            val_ff <= 1'b0;
        end else begin
            ea_ff <= nxt_ea;
            imm_ff <= nxt_imm;
            ptr_ff <= nxt_ptr;
            cyc_ff <= nxt_cyc;
            len_ff <= nxt_len;
            blkc_ff <= nxt_blkc;
            bsrc_ff <= nxt_bsrc;
            bdst_ff <= nxt_bdst;
            val_ff <= nxt_val;
        end
    end

    // =========================================================
    // program counter and program bank
    logic [15:0] pc_ff;
    logic [15:0] nxt_pc;
    logic [7:0] pbr_ff;
    logic [7:0] nxt_pbr;
    always_comb begin
        nxt_pc = pc_ff;
        nxt_pbr = pbr_ff;
        if (PC_LOAD) begin
            nxt_pc = PC_NEW;
        end else if (PC_INC) begin
            nxt_pc = pc_ff + 16'h0001;
        end
        case (PB_OP)
            CPUAMG_PB_RTI, CPUAMG_PB_RTL, CPUAMG_PB_JML, CPUAMG_PB_JSL, CPUAMG_PB_JMPL: begin
                nxt_pbr = PB_NEW;
            end
            default: begin
                nxt_pbr = pbr_ff;
            end
        endcase
    end
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pc_ff <= CPUAMG_RST_PC;
            pbr_ff <= CPUAMG_RST_PBR;
        end else begin
            pc_ff <= nxt_pc;
            pbr_ff <= nxt_pbr;
        end
    end

    // =========================================================
    // outputs
    assign EFF_ADDR = ea_ff;
    assign BANK_PINS = BANK_OUT_EN ? ea_ff[23:16] : 8'h00;
    assign IMM_OPERAND = imm_ff;
    assign PTR_ADDR = ptr_ff;
    assign CYCLES = cyc_ff;
    assign PROG_BYTES = len_ff;
    assign BLK_COUNT = blkc_ff;
    assign BLK_SRC = bsrc_ff;
    assign BLK_DST = bdst_ff;
    assign PC_OUT = pc_ff;
    assign PBR_OUT = pbr_ff;
    assign VALID = val_ff;
endmodule // cpuamg_top

/* File: test/cpuamg_monitor.sv */
// concurrent checks on the ports of the address mode generator
`timescale 1ns/1ns
module cpuamg_monitor
    import cpuamg_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic START,
    input wire cpuamg_mode_t MODE,
    input wire logic [7:0] OP_B2,
    input wire logic [7:0] OP_B3,
    input wire logic [7:0] OP_B4,
    input wire logic [7:0] DATA_BANK_REG,
    input wire logic [3:0] VEC_SEL,
    input wire logic RMW,
    input wire logic BRANCH_TAKEN,
    input wire logic PC_INC,
    input wire logic PC_LOAD,
    input wire cpuamg_pbop_t PB_OP,
    input wire logic BANK_OUT_EN,
    input wire logic [23:0] EFF_ADDR,
    input wire logic [7:0] BANK_PINS,
    input wire logic [3:0] CYCLES,
    input wire logic [2:0] PROG_BYTES,
    input wire logic [15:0] PC_OUT,
    input wire logic [7:0] PBR_OUT,
    input wire logic VALID
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    // =========================================================
    // sequences
    sequence s_take(cpuamg_mode_t m);
        START && MODE == m;
    endsequence
    sequence s_answer;
        VALID ##1 !VALID;
    endsequence
    // =========================================================
    // properties
    property p_vec;
        s_take(CPUAMG_M_VEC) |=> EFF_ADDR == (24'h00FFE0 | {20'h00000, $past(VEC_SEL)});
    endproperty
    property p_stk;
        START && (MODE == CPUAMG_M_STK || MODE == CPUAMG_M_SR) |=> EFF_ADDR[23:16] == 8'h00;
    endproperty
    property p_dir;
        START && MODE inside {CPUAMG_M_DIR, CPUAMG_M_DX, CPUAMG_M_DY}
            |=> EFF_ADDR[23:16] == 8'h00;
    endproperty
    property p_abs;
        s_take(CPUAMG_M_ABS) |=> EFF_ADDR == {$past(DATA_BANK_REG), $past(OP_B3), $past(OP_B2)};
    endproperty
    property p_absl;
        s_take(CPUAMG_M_ABSL) |=> EFF_ADDR == {$past(OP_B4), $past(OP_B3), $past(OP_B2)};
    endproperty
    property p_acc;
        START && MODE == CPUAMG_M_ACC && !RMW |=> CYCLES == 4'h2 && PROG_BYTES == 3'h1;
    endproperty
    property p_rel;
        START && MODE == CPUAMG_M_REL && !RMW |=> CYCLES == 4'h2 + {3'h0, $past(BRANCH_TAKEN)};
    endproperty
    property p_pbr_hold;
        PB_OP == CPUAMG_PB_NONE |=> $stable(PBR_OUT);
    endproperty
    property p_pc_wrap;
        PC_INC && !PC_LOAD && PC_OUT == 16'hFFFF |=> PC_OUT == 16'h0000;
    endproperty
    property p_valid;
        START ##1 !START |-> s_answer;
    endproperty
    property p_pins;
        !BANK_OUT_EN |-> BANK_PINS == 8'h00;
    endproperty
    // =========================================================
    // assertions
    a_vec: assert property (p_vec) else $error("vector address wrong");
    a_stk: assert property (p_stk) else $error("stack bank not zero");
    a_dir: assert property (p_dir) else $error("direct bank not zero");
    a_abs: assert property (p_abs) else $error("absolute address wrong");
    a_absl: assert property (p_absl) else $error("long address wrong");
    a_acc: assert property (p_acc) else $error("accumulator count wrong");
    a_rel: assert property (p_rel) else $error("branch cycles wrong");
    a_pbr_hold: assert property (p_pbr_hold) else $error("program bank changed");
    a_pc_wrap: assert property (p_pc_wrap) else $error("pc left its bank");
    a_valid: assert property (p_valid) else $error("valid not one cycle");
    a_pins: assert property (p_pins) else $error("bank pins not zero");
endmodule // cpuamg_monitor
bind cpuamg_top cpuamg_monitor cpuamg_monitor_b (.MCLK(MCLK), .RESET_N(RESET_N), .START(START),
    .MODE(MODE), .OP_B2(OP_B2), .OP_B3(OP_B3), .OP_B4(OP_B4), .DATA_BANK_REG(DATA_BANK_REG),
    .VEC_SEL(VEC_SEL), .RMW(RMW), .BRANCH_TAKEN(BRANCH_TAKEN), .PC_INC(PC_INC),
    .PC_LOAD(PC_LOAD), .PB_OP(PB_OP), .BANK_OUT_EN(BANK_OUT_EN), .EFF_ADDR(EFF_ADDR),
    .BANK_PINS(BANK_PINS), .CYCLES(CYCLES), .PROG_BYTES(PROG_BYTES), .PC_OUT(PC_OUT),
    .PBR_OUT(PBR_OUT), .VALID(VALID));

/* File: test/cpuamg_mem_model.sv */
// memory model answering pointer reads in bank zero
`timescale 1ns/1ns
module cpuamg_mem_model (
    input wire logic [15:0] addr,
    output logic [15:0] data,
    output logic [7:0] bank
);
    // =========================================================
    // fixed pattern contents, word and third byte per address
    always_comb begin
        data = addr ^ 16'hA5C3;
        bank = addr[7:0] ^ 8'h3C;
    end
endmodule // cpuamg_mem_model

/* File: test/tb.sv */
// self-checking testbench for the address mode generator
`timescale 1ns/1ns
module tb;
    import cpuamg_pkg::*;
    logic MCLK = 1'b0, RESET_N = 1'b0, START = 1'b0, M_FLAG = 1'b1, X_FLAG = 1'b1;
    logic IDX_OP = 1'b0, RMW = 1'b0, BRANCH_TAKEN = 1'b0, PC_INC = 1'b0, PC_LOAD = 1'b0;
    logic BANK_OUT_EN = 1'b1;
    cpuamg_mode_t MODE = CPUAMG_M_IMPL;
    cpuamg_pbop_t PB_OP = CPUAMG_PB_NONE;
    logic [7:0] OP_B2 = 8'h00, OP_B3 = 8'h00, OP_B4 = 8'h00, DATA_BANK_REG = 8'h7E;
    logic [7:0] STACK_CYCLES = 8'h03, PB_NEW = 8'h00, PTR_BANK;
    logic [15:0] DIRECT_PAGE = 16'h0000, X_REG = 16'h0000, Y_REG = 16'h0000;
    logic [15:0] S_REG = 16'h01F0, C_ACC = 16'h0000, PC_NEW = 16'h0000, PTR_DATA;
    logic [3:0] VEC_SEL = 4'h0;
    logic [23:0] EFF_ADDR, BLK_SRC, BLK_DST;
    logic [15:0] IMM_OPERAND, PTR_ADDR, BLK_COUNT, PC_OUT;
    logic [7:0] BANK_PINS, PBR_OUT;
    logic [3:0] CYCLES;
    logic [2:0] PROG_BYTES;
    logic VALID;
    int mismatches = 0, compares = 0, cyc = 0;
    cpuamg_top cpuamg_top_i (.MCLK(MCLK), .RESET_N(RESET_N), .START(START), .MODE(MODE),
        .OP_B2(OP_B2), .OP_B3(OP_B3), .OP_B4(OP_B4), .PTR_DATA(PTR_DATA), .PTR_BANK(PTR_BANK),
        .DATA_BANK_REG(DATA_BANK_REG), .DIRECT_PAGE(DIRECT_PAGE), .X_REG(X_REG),
        .Y_REG(Y_REG), .S_REG(S_REG), .C_ACC(C_ACC), .VEC_SEL(VEC_SEL), .M_FLAG(M_FLAG),
        .X_FLAG(X_FLAG), .IDX_OP(IDX_OP), .RMW(RMW), .BRANCH_TAKEN(BRANCH_TAKEN),
        .STACK_CYCLES(STACK_CYCLES), .PC_INC(PC_INC), .PC_LOAD(PC_LOAD), .PC_NEW(PC_NEW),
        .PB_OP(PB_OP), .PB_NEW(PB_NEW), .BANK_OUT_EN(BANK_OUT_EN), .EFF_ADDR(EFF_ADDR),
        .BANK_PINS(BANK_PINS), .IMM_OPERAND(IMM_OPERAND), .PTR_ADDR(PTR_ADDR),
        .CYCLES(CYCLES), .PROG_BYTES(PROG_BYTES), .BLK_COUNT(BLK_COUNT), .BLK_SRC(BLK_SRC),
        .BLK_DST(BLK_DST), .PC_OUT(PC_OUT), .PBR_OUT(PBR_OUT), .VALID(VALID));
    cpuamg_mem_model cpuamg_mem_model_i (.addr(PTR_ADDR), .data(PTR_DATA), .bank(PTR_BANK));
    // =========================================================
    // clock, timeout and helpers
    initial begin
        forever #4 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            mismatches = mismatches + 1;
            end_sim();
        end
    end
    task automatic end_sim();
        if (mismatches == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one request taken at the next rising edge, results read at the falling edge that follows it
    task automatic go(input cpuamg_mode_t m);
        MODE = m;
        START = 1'b1;
        @(negedge MCLK);
        START = 1'b0;
        chk(VALID, 1'b1);
    endtask
    task automatic cb(input logic [3:0] c, input logic [2:0] b);
        chk(CYCLES, c);
        chk(PROG_BYTES, b);
    endtask
    // =========================================================
    // scenarios
    task automatic t_abs();
        OP_B2 = 8'h34; OP_B3 = 8'h12; OP_B4 = 8'h9A;
        go(CPUAMG_M_ABS);
        chk(EFF_ADDR, 24'h7E1234);
        cb(4'h4, 3'h3);
        @(negedge MCLK);
        chk(VALID, 1'b0);
        RMW = 1'b1;
        go(CPUAMG_M_ABS);
        chk(CYCLES, 4'h6);
        M_FLAG = 1'b0;
        go(CPUAMG_M_ABS);
        chk(CYCLES, 4'h8);
        RMW = 1'b0;
        go(CPUAMG_M_ABSL);
        chk(EFF_ADDR, 24'h9A1234);
        cb(4'h6, 3'h4);
        M_FLAG = 1'b1;
        chk(BANK_PINS, 8'h9A);
        BANK_OUT_EN = 1'b0;
        #1 chk(BANK_PINS, 8'h00);
        @(negedge MCLK);
        BANK_OUT_EN = 1'b1;
    endtask
    task automatic t_imm();
        OP_B2 = 8'hAB; OP_B3 = 8'hCD;
        go(CPUAMG_M_IMM);
        chk(IMM_OPERAND[7:0], 8'hAB);
        cb(4'h2, 3'h2);
        M_FLAG = 1'b0;
        go(CPUAMG_M_IMM);
        chk(IMM_OPERAND, 16'hCDAB);
        cb(4'h3, 3'h3);
        M_FLAG = 1'b1;
    endtask
    task automatic t_dir();
        DIRECT_PAGE = 16'hFF10; OP_B2 = 8'hF5;
        go(CPUAMG_M_DIR);
        chk(EFF_ADDR, 24'h000005);
        cb(4'h4, 3'h2);
        DIRECT_PAGE = 16'h0100; X_REG = 16'h0002; OP_B2 = 8'h10;
        go(CPUAMG_M_DX);
        chk(EFF_ADDR, 24'h000112);
        cb(4'h4, 3'h2);
        Y_REG = 16'hFFF0;
        go(CPUAMG_M_DY);
        chk(EFF_ADDR, 24'h000100);
        DIRECT_PAGE = 16'h0000;
    endtask
    task automatic t_index();
        OP_B2 = 8'hF0; OP_B3 = 8'h12; OP_B4 = 8'hFF; X_REG = 16'h0020;
        go(CPUAMG_M_AX);
        chk(EFF_ADDR, 24'h7E1310);
        cb(4'h5, 3'h3);
        OP_B3 = 8'hFF;
        go(CPUAMG_M_ALX);
        chk(EFF_ADDR, 24'h000010);
        cb(4'h5, 3'h4);
        OP_B2 = 8'h40; Y_REG = 16'h5A80;
        go(CPUAMG_M_DIIY);
        chk(PTR_ADDR, 16'h0040);
        go(CPUAMG_M_DIIY);
        chk(EFF_ADDR, 24'h7F0003);
        cb(4'h6, 3'h2);
        go(CPUAMG_M_DXI);
        cb(4'h6, 3'h2);
        go(CPUAMG_M_DIL);
        chk(EFF_ADDR, 24'h5CA5A3);
        cb(4'h6, 3'h2);
        go(CPUAMG_M_DILY);
        chk(EFF_ADDR, 24'h7D0003);
        go(CPUAMG_M_DI);
        chk(EFF_ADDR, 24'h7EA583);
        cb(4'h5, 3'h2);
        X_FLAG = 1'b0;
        IDX_OP = 1'b1;
        go(CPUAMG_M_AY);
        chk(EFF_ADDR, 24'h7F59C0);
        chk(CYCLES, 4'h6);
        X_FLAG = 1'b1;
        IDX_OP = 1'b0;
    endtask
    task automatic t_stack();
        OP_B2 = 8'h20; S_REG = 16'hFFF0; STACK_CYCLES = 8'h08;
        go(CPUAMG_M_SR);
        chk(EFF_ADDR, 24'h000010);
        cb(4'h4, 3'h2);
        go(CPUAMG_M_STK);
        chk(EFF_ADDR[23:16], 8'h00);
        chk(CYCLES, 4'h8);
        for (int i = 0; i < 16; i++) begin
            VEC_SEL = i[3:0];
            go(CPUAMG_M_VEC);
            chk(EFF_ADDR, 24'h00FFE0 | {20'h00000, VEC_SEL});
        end
    endtask
    task automatic t_cycles();
        go(CPUAMG_M_ACC);
        cb(4'h2, 3'h1);
        go(CPUAMG_M_REL);
        cb(4'h2, 3'h2);
        BRANCH_TAKEN = 1'b1;
        go(CPUAMG_M_REL);
        chk(CYCLES, 4'h3);
        go(CPUAMG_M_RELL);
        cb(4'h4, 3'h3);
        BRANCH_TAKEN = 1'b0;
        go(CPUAMG_M_AXI);
        cb(4'h6, 3'h3);
        M_FLAG = 1'b0;
        go(CPUAMG_M_SRIY);
        cb(4'h8, 3'h2);
        M_FLAG = 1'b1;
        OP_B2 = 8'h05; OP_B3 = 8'h03; X_REG = 16'h1111; Y_REG = 16'h2222;
        C_ACC = 16'h0042;
        go(CPUAMG_M_BLK);
        cb(4'h7, 3'h3);
        chk(BLK_SRC, 24'h031111);
        chk(BLK_DST, 24'h052222);
        chk(BLK_COUNT, 16'h0042);
        chk(EFF_ADDR, 24'h031111);
    endtask
    task automatic t_pc();
        PC_NEW = 16'hFFFF; PC_LOAD = 1'b1;
        @(negedge MCLK);
        PC_LOAD = 1'b0; PC_INC = 1'b1;
        @(negedge MCLK);
        PC_INC = 1'b0;
        chk(PC_OUT, 16'h0000);
        chk(PBR_OUT, 8'h00);
        for (int i = 1; i < 6; i++) begin
            PB_OP = cpuamg_pbop_t'(i[2:0]); PB_NEW = 8'h40 + i[7:0];
            @(negedge MCLK);
            chk(PBR_OUT, 8'h40 + i[7:0]);
        end
        PB_OP = CPUAMG_PB_NONE; PB_NEW = 8'hEE;
        go(CPUAMG_M_AIND);
        cb(4'h5, 3'h3);
        chk(PBR_OUT, 8'h45);
    endtask
    // =========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge MCLK);
        @(negedge MCLK);
        RESET_N = 1'b1;
        t_abs();
        t_imm();
        t_dir();
        t_index();
        t_stack();
        t_cycles();
        t_pc();
        end_sim();
    end
endmodule // tb
